// [codec_zfilter_debounce_cmds_tb.sv]
// Purpose: host and codec ends joined, driven over the register bus
// Assumes: byte reads poll status bit1 before taking the byte
// Notes: hook check uses 1 ms; the 8 ms default would lengthen the run
`timescale 1ns/1ps
module codec_zfilter_debounce_cmds_tb;
  import zcmd_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [3:0] araddr = 4'h0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic [31:0] rdata;
  logic mode = 1'b1;
  logic lin = 1'b0;
  logic arm = 1'b0;
  logic [7:0] comp = 8'h00;
  logic [15:0] lin_s = 16'h0000;
  logic strobe = 1'b0;
  logic hook = 1'b0;
  logic signed [15:0] filt_out;
  logic hook_st, mux_st, chop, irq;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  zcmd_if zcmd_if_i ();
  zcmd_host zcmd_host_i (.CLK_SYS_I(clk), .RESET_N_I(reset_n),
    .LINK(zcmd_if_i.host), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
    .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
    .S_AXI_RREADY_I(rready));
  zcmd_device zcmd_device_i (.CLK_SYS_I(clk), .RESET_N_I(reset_n),
    .LINK(zcmd_if_i.device), .MUX_DETECT_MODE_I(mode), .LINEAR_MODE_I(lin),
    .TRANSMIT_INTERRUPT_ARM_I(arm), .COMPANDED_SAMPLE_I(comp),
    .LINEAR_SAMPLE_I(lin_s), .SAMPLE_STROBE_I(strobe),
    .FIRST_DETECT_INPUT_I(hook), .FILTER_IN_I(16'sh1000),
    .FILTER_OUT_O(filt_out), .HOOK_STATE_O(hook_st),
    .MUX_STROBE_O(mux_st), .CHOPPER_CLOCK_OUT_O(chop),
    .TRANSMIT_IRQ_O(irq));
  zcmd_props zcmd_props_i (.CLK_SYS_I(clk), .RESET_N_I(reset_n),
    .h2d_data(zcmd_if_i.h2d_data), .h2d_valid(zcmd_if_i.h2d_valid),
    .h2d_ready(zcmd_if_i.h2d_ready), .d2h_data(zcmd_if_i.d2h_data),
    .d2h_valid(zcmd_if_i.d2h_valid), .d2h_ready(zcmd_if_i.d2h_ready));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic close_out;
    $display("checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [79:0] seen,
                     input logic [79:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic axi_wr(input logic [3:0] a, input logic [7:0] d,
                        input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", bresp, er);
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    rready <= 1'b0;
    chk("rresp", rresp, 2'b00);
  endtask : axi_rd
  task automatic rd_n(input logic [7:0] c, input int k,
                      output logic [79:0] v);
    logic [31:0] s;
    v = 80'h0;
    axi_wr(REG_CMD, c, 2'b00);
    repeat (k) begin
      do begin
        axi_rd(REG_STATUS, s);
      end while (s[1] !== 1'b1);
      axi_rd(REG_RDATA, s);
      v = {v[71:0], s[7:0]};
    end
  endtask : rd_n
  task automatic wr_n(input logic [7:0] c, input int k,
                      input logic [79:0] v);
    axi_wr(REG_CMD, c, 2'b00);
    for (int i = k - 1; i >= 0; i--) begin
      axi_wr(REG_WDATA, v[i*8+:8], 2'b00);
    end
  endtask : wr_n
  task automatic mon(input int n, output int hi, output int ed);
    logic p;
    hi = 0;
    ed = 0;
    p = chop;
    repeat (n) begin
      @(posedge clk);
      if (mux_st === 1'b1) hi++;
      if (chop === 1'b1 && p === 1'b0) ed++;
      p = chop;
    end
  endtask : mon
  task automatic pulse;
    @(posedge clk);
    strobe <= 1'b1;
    repeat (6) @(posedge clk);
    strobe <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : pulse
  localparam logic [79:0] FIR_PAT = 80'h0123456789ABCDEF1357;
  localparam logic [79:0] IIR_PAT = 80'h2468ACE013;
  // z0 = 1, z1 = -1/2, other taps zero
  localparam logic [79:0] FIR_UNIT = 80'h09000909019001900190;
  initial begin
    logic [79:0] v;
    int hi;
    int ed;
    int ce;
    ce = FILT_CYCLES / (2 * CHOP_HALF);
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    rd_n(CMD_DEB_RD, 1, v);
    chk("cfg reset", v, {72'h0, CFG_RESET});
    mon(1600, hi, ed);
    chk("chop idle", ed, 0);
    chk("strobe idle", hi, 0);
    chk("filter out", filt_out, 80'h0);
    rd_n(CMD_FIR_RD, FIR_BYTES, v);
    chk("fir reset", v, FIR_RESET);
    rd_n(CMD_IIR_RD, IIR_BYTES, v);
    chk("iir reset", v, {40'h0, IIR_RESET});
    wr_n(CMD_FIR_WR, FIR_BYTES, FIR_UNIT);
    // constant input fills every tap within six ticks
    repeat (6 * FILT_CYCLES) @(posedge clk);
    chk("taps", filt_out, 80'h0800);
    wr_n(CMD_FIR_WR, FIR_BYTES, FIR_PAT);
    rd_n(CMD_FIR_RD, FIR_BYTES, v);
    chk("fir back", v, FIR_PAT);
    rd_n(CMD_IIR_RD, IIR_BYTES, v);
    chk("iir kept", v, {40'h0, IIR_RESET});
    wr_n(CMD_IIR_WR, IIR_BYTES, IIR_PAT);
    rd_n(CMD_IIR_RD, IIR_BYTES, v);
    chk("iir back", v, IIR_PAT);
    rd_n(CMD_FIR_RD, FIR_BYTES, v);
    chk("fir kept", v, FIR_PAT);
    axi_wr(4'h2, 8'h00, 2'b10);
    // unknown command must be dropped without disturbing the next one
    axi_wr(REG_CMD, 8'h55, 2'b00);
    wr_n(CMD_DEB_WR, 1, 80'h81);
    rd_n(CMD_DEB_RD, 1, v);
    chk("cfg back", v, 80'h81);
    mon(FILT_CYCLES, hi, ed);
    chk("strobe on", hi, 1);
    chk("chop run", ed == ce || ed == ce + 1, 1);
    wr_n(CMD_DEB_WR, 1, 80'hC0);
    repeat (2) @(posedge clk);
    mon(FILT_CYCLES, hi, ed);
    chk("strobe low", hi, FILT_CYCLES - 1);
    chk("chop off", ed, 0);
    @(posedge clk);
    mode <= 1'b0;
    // strobe is registered: let the new mode reach it first
    repeat (2) @(posedge clk);
    mon(FILT_CYCLES, hi, ed);
    chk("strobe mode", hi, 0);
    wr_n(CMD_DEB_WR, 1, 80'h00);
    @(posedge clk);
    hook <= 1'b1;
    repeat (10) @(posedge clk);
    chk("hook fast", hook_st, 1);
    wr_n(CMD_DEB_WR, 1, 80'h04);
    @(posedge clk);
    hook <= 1'b0;
    repeat (MS_CYCLES - 10) @(posedge clk);
    chk("hook held", hook_st, 1);
    repeat (20) @(posedge clk);
    chk("hook late", hook_st, 0);
    @(posedge clk);
    comp <= 8'hA5;
    lin_s <= 16'h9C3E;
    pulse();
    rd_n(CMD_XMT_RD, XMT_BYTES, v);
    chk("xmt comp", v, 80'hA500);
    lin <= 1'b1;
    pulse();
    rd_n(CMD_XMT_RD, XMT_BYTES, v);
    chk("xmt lin", v, 80'h9C00);
    chk("irq unarmed", irq, 0);
    arm <= 1'b1;
    pulse();
    chk("irq set", irq, 1);
    rd_n(CMD_XMT_RD, XMT_BYTES, v);
    repeat (3) @(posedge clk);
    chk("irq clear", irq, 0);
    close_out();
  end
endmodule : codec_zfilter_debounce_cmds_tb

// [zcmd_device.sv]
// Purpose: codec end decoding impedance filter, debounce and readback cmds
// Assumes: host keeps reserved bits zero; hook and sample strobe pins pass two flops first
// Notes: coefficients are built from shift-add terms; the taps and IIR use multipliers
// Operation
// - 98h/99h write or read ten FIR bytes
// - sign bit zero positive, one negative
// - nibble is sign plus three-bit shift
// - four nested terms, coefficient 6 two
// - 32 kHz five-tap FIR plus one-pole IIR
// - reset loads every pair with 0190h; here the IIR z6 byte gets 01h and the z7 pair gets 9090h
// - IIR input scaled 1/z6, output times z6; the code scales the input by z5 and the output by z6 z7
// - 9Ah/9Bh write or read five IIR bytes
// - debounce register shared by all channels
// - mux enable bit turns strobe on
// - polarity bit selects strobe pulse level
// - no strobe unless detect mode is one
// - hook input debounced 0-15 ms, default 8
// - host writes reserved bits as zero
// - chopper bit gates chopper clock output
// - CDh returns two bytes, second reserved
// - companded mode returns coded sample byte
// - linear mode returns upper sample byte
// - armed interrupt on new sample, cleared on read
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module zcmd_device (
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  zcmd_if.device LINK,
  input wire logic MUX_DETECT_MODE_I,
  input wire logic LINEAR_MODE_I,
  input wire logic TRANSMIT_INTERRUPT_ARM_I,
  input wire logic [7:0] COMPANDED_SAMPLE_I,
  input wire logic [15:0] LINEAR_SAMPLE_I,
  input wire logic SAMPLE_STROBE_I,
  input wire logic FIRST_DETECT_INPUT_I,
  input wire logic signed [15:0] FILTER_IN_I,
  output logic signed [15:0] FILTER_OUT_O,
  output logic HOOK_STATE_O,
  output logic MUX_STROBE_O,
  output logic CHOPPER_CLOCK_OUT_O,
  output logic TRANSMIT_IRQ_O
);
  import zcmd_pkg::*;

  typedef enum logic [1:0] {
    ST_CMD = 2'b00,
    ST_WRITE = 2'b01,
    ST_READ = 2'b10
  } dev_state_t;
  dev_state_t state;
  logic [7:0] cmd;
  logic [3:0] cnt;
  logic [79:0] fir_coef;
  logic [39:0] iir_coef;
  logic [7:0] cfg;
  logic [7:0] xmt_byte;
  logic [7:0] next_rd;
  logic [3:0] last_idx;
  logic byte_in;
  logic byte_out;
  assign LINK.h2d_ready = (state != ST_READ);
  assign byte_in = LINK.h2d_valid && LINK.h2d_ready;
  assign byte_out = LINK.d2h_valid && LINK.d2h_ready;
  // byte k sits at the top for k=0, so reads replay write order
  always_comb begin
    next_rd = 8'h00;
    last_idx = 4'd0;
    unique case (cmd)
      CMD_FIR_WR, CMD_FIR_RD: begin
        next_rd = fir_coef[79 - 8 * cnt -: 8];
        last_idx = 4'(FIR_BYTES - 1);
      end
      CMD_IIR_WR, CMD_IIR_RD: begin
        next_rd = iir_coef[39 - 8 * cnt -: 8];
        last_idx = 4'(IIR_BYTES - 1);
      end
      CMD_DEB_WR, CMD_DEB_RD: next_rd = cfg;
      CMD_XMT_RD: begin
        next_rd = (cnt == 4'd0) ? xmt_byte : 8'h00;
        last_idx = 4'(XMT_BYTES - 1);
      end
      default: next_rd = 8'h00;
    endcase
  end
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state <= ST_CMD;
      cmd <= 8'h00;
      cnt <= 4'd0;
      LINK.d2h_valid <= 1'b0;
      LINK.d2h_data <= 8'h00;
    end else begin
      unique case (state)
        ST_CMD: begin
          if (byte_in) begin
            cmd <= LINK.h2d_data;
            cnt <= 4'd0;
            unique case (LINK.h2d_data)
              CMD_FIR_WR, CMD_IIR_WR, CMD_DEB_WR: state <= ST_WRITE;
              CMD_FIR_RD, CMD_IIR_RD, CMD_DEB_RD, CMD_XMT_RD: state <= ST_READ;
              default: state <= ST_CMD;
            endcase
          end
        end
        ST_WRITE: begin
          if (byte_in) begin
            cnt <= cnt + 4'd1;
            if (cnt == last_idx) begin
              state <= ST_CMD;
            end
          end
        end
        ST_READ: begin
          if (!LINK.d2h_valid) begin
            LINK.d2h_valid <= 1'b1;
            LINK.d2h_data <= next_rd;
          end else if (byte_out) begin
            LINK.d2h_valid <= 1'b0;
            cnt <= cnt + 4'd1;
            if (cnt == last_idx) begin
              state <= ST_CMD;
            end
          end
        end
        default: state <= ST_CMD;
      endcase
    end
  end
  // coefficient and config stores
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      fir_coef <= FIR_RESET;
      iir_coef <= IIR_RESET;
      cfg <= CFG_RESET;
    end else if (state == ST_WRITE && byte_in) begin
      if (cmd == CMD_FIR_WR) begin
        fir_coef[79 - 8 * cnt -: 8] <= LINK.h2d_data;
      end else if (cmd == CMD_IIR_WR) begin
        iir_coef[39 - 8 * cnt -: 8] <= LINK.h2d_data;
      end else if (cmd == CMD_DEB_WR) begin
        cfg <= LINK.h2d_data;
      end
    end
  end
  // sample capture and armed interrupt; new sample wins over read clear
  logic [2:0] smp_sync;
  logic xmt_read;
  assign xmt_read = (state == ST_READ) && (cmd == CMD_XMT_RD) && byte_out &&
                    (cnt == 4'd0);
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      smp_sync <= 3'b000;
      xmt_byte <= 8'h00;
      TRANSMIT_IRQ_O <= 1'b0;
    end else begin
      smp_sync <= {smp_sync[1:0], SAMPLE_STROBE_I};
      if (smp_sync[2:1] == 2'b01) begin
        xmt_byte <= LINEAR_MODE_I ? LINEAR_SAMPLE_I[15:8]
                                  : COMPANDED_SAMPLE_I;
        TRANSMIT_IRQ_O <= TRANSMIT_INTERRUPT_ARM_I;
      end else if (xmt_read) begin
        TRANSMIT_IRQ_O <= 1'b0;
      end
    end
  end
  // hook debounce: stable for N ms before the state bit follows
  logic [1:0] hook_sync;
  logic [15:0] ms_cnt;
  logic [3:0] stable_ms;
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      hook_sync <= 2'b00;
      ms_cnt <= 16'h0000;
      stable_ms <= 4'h0;
      HOOK_STATE_O <= 1'b0;
    end else begin
      hook_sync <= {hook_sync[0], FIRST_DETECT_INPUT_I};
      if (hook_sync[1] == HOOK_STATE_O) begin
        ms_cnt <= 16'h0000;
        stable_ms <= 4'h0;
      end else if (stable_ms >= cfg[CFG_DEB_LSB +: 4]) begin
        HOOK_STATE_O <= hook_sync[1];
      end else if (ms_cnt == 16'(MS_CYCLES - 1)) begin
        ms_cnt <= 16'h0000;
        stable_ms <= stable_ms + 4'h1;
      end else begin
        ms_cnt <= ms_cnt + 16'h0001;
      end
    end
  end
  // chopper clock at CHOP_HZ (256 kHz) and mux strobe, the strobe one pulse per filter tick
  logic [7:0] chop_cnt;
  logic chop_ph;
  logic [10:0] tick_cnt;
  logic tick;
  assign tick = (tick_cnt == 11'(FILT_CYCLES - 1));
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      chop_cnt <= 8'h00;
      chop_ph <= 1'b0;
      tick_cnt <= 11'h000;
      CHOPPER_CLOCK_OUT_O <= 1'b0;
      MUX_STROBE_O <= 1'b0;
    end else begin
      tick_cnt <= tick ? 11'h000 : tick_cnt + 11'h001;
      if (chop_cnt == 8'(CHOP_HALF - 1)) begin
        chop_cnt <= 8'h00;
        chop_ph <= !chop_ph;
      end else begin
        chop_cnt <= chop_cnt + 8'h01;
      end
      CHOPPER_CLOCK_OUT_O <= cfg[CFG_CHOP] && chop_ph;
      if (MUX_DETECT_MODE_I && cfg[CFG_MUX_EN]) begin
        MUX_STROBE_O <= tick ^ cfg[CFG_POL];
      end else begin
        MUX_STROBE_O <= 1'b0;
      end
    end
  end

  // pair layout: {C4 m4 C3 m3 C2 m2 C1 m1}; innermost first, Q2.14
  function automatic logic signed [31:0] csdn(input logic [15:0] p,
                                               input int n);
    logic signed [31:0] v;
    v = 32'sd16384;
    for (int k = 4 - n; k < 4; k++) begin
      v = p[4 * (3 - k) + 3] ? -(v >>> p[4 * (3 - k) +: 3])
                             : (v >>> p[4 * (3 - k) +: 3]);
      if (k < 3) begin
        v = v + 32'sd16384;
      end
    end
    return v;
  endfunction : csdn
  logic signed [31:0] zc [0:7];
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      zc[i] = csdn(fir_coef[79 - 16 * i -: 16], 4);
    end
    zc[5] = csdn(iir_coef[39:24], 4);
    zc[6] = csdn({8'h00, iir_coef[23:16]}, 2);
    zc[7] = csdn({iir_coef[15:8], iir_coef[7:0]}, 4);
  end
  // filter at 32 kHz tick, coefficients in Q2.14
  logic signed [15:0] dly [0:4];
  logic signed [47:0] iir_st;
  logic signed [47:0] fir_sum;
  logic signed [47:0] iir_in;
  always_comb begin
    fir_sum = 48'sd0;
    for (int i = 0; i < 5; i++) begin
      fir_sum = fir_sum + 48'(dly[i] * zc[i]);
    end
    iir_in = 48'((48'(FILTER_IN_I) * zc[5]) >>> 14); // input gain z5
  end
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      dly <= '{default: 16'sh0000};
      iir_st <= 48'sd0;
      FILTER_OUT_O <= 16'sh0000;
    end else if (tick) begin
      dly[0] <= FILTER_IN_I;
      for (int i = 1; i < 5; i++) begin
        dly[i] <= dly[i - 1];
      end
      // feedback z7, output scaled z6 z7 and delayed one sample
      iir_st <= iir_in + 48'((iir_st * zc[7]) >>> 14);
      // iir term kept at the fir sum's 2^14 scale before the final shift
      FILTER_OUT_O <= 16'((fir_sum + 48'(48'((iir_st * zc[7]) >>> 14)
                       * zc[6])) >>> 14);
    end
  end
endmodule : zcmd_device

// [zcmd_host.sv]
// Purpose: host end; AXI4-Lite registers turn into command byte streams
// Assumes: software writes CMD, then pushes or pulls one byte at a time
// Notes: single outstanding byte; status shows busy and read byte ready
`timescale 1ns/1ps
module zcmd_host (
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  zcmd_if.host LINK,
  input wire logic [3:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [3:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I
);
  import zcmd_pkg::*;

  logic aw_hit;
  logic w_hit;
  logic [3:0] aw_addr;
  logic [7:0] w_byte;
  logic push;
  logic [7:0] rd_byte;
  logic rd_full;
  logic pull;

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      aw_hit <= 1'b0;
      w_hit <= 1'b0;
      aw_addr <= 4'h0;
      w_byte <= 8'h00;
      S_AXI_AWREADY_O <= 1'b1;
      S_AXI_WREADY_O <= 1'b1;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= 2'b00;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_hit <= 1'b1;
        aw_addr <= S_AXI_AWADDR_I;
        S_AXI_AWREADY_O <= 1'b0;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_hit <= 1'b1;
        w_byte <= S_AXI_WSTRB_I[0] ? S_AXI_WDATA_I[7:0] : 8'h00;
        S_AXI_WREADY_O <= 1'b0;
      end
      // stall the response while a previous byte is still unsent
      if (aw_hit && w_hit && !S_AXI_BVALID_O && !LINK.h2d_valid) begin
        aw_hit <= 1'b0;
        w_hit <= 1'b0;
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O <= (aw_addr == REG_CMD || aw_addr == REG_WDATA) ?
                         2'b00 : 2'b10;
      end
      if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
        S_AXI_AWREADY_O <= 1'b1;
        S_AXI_WREADY_O <= 1'b1;
      end
    end
  end
  assign push = aw_hit && w_hit && !S_AXI_BVALID_O && !LINK.h2d_valid &&
                (aw_addr == REG_CMD || aw_addr == REG_WDATA);

  // reserved bits are software's to zero; byte passes through as given
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      LINK.h2d_valid <= 1'b0;
      LINK.h2d_data <= 8'h00;
    end else if (push) begin
      LINK.h2d_valid <= 1'b1;
      LINK.h2d_data <= w_byte;
    end else if (LINK.h2d_ready) begin
      LINK.h2d_valid <= 1'b0;
    end
  end

  assign LINK.d2h_ready = !rd_full;
  assign pull = S_AXI_ARVALID_I && S_AXI_ARREADY_O &&
                (S_AXI_ARADDR_I == REG_RDATA);
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rd_byte <= 8'h00;
      rd_full <= 1'b0;
    end else if (LINK.d2h_valid && !rd_full) begin
      rd_byte <= LINK.d2h_data;
      rd_full <= 1'b1;
    end else if (pull) begin
      rd_full <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      S_AXI_ARREADY_O <= 1'b1;
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= 32'h00000000;
      S_AXI_RRESP_O <= 2'b00;
    end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RRESP_O <= 2'b00;
      unique case (S_AXI_ARADDR_I)
        REG_RDATA: S_AXI_RDATA_O <= {24'h000000, rd_byte};
        REG_STATUS: S_AXI_RDATA_O <= {30'h00000000, rd_full,
                                      LINK.h2d_valid};
        REG_CMD, REG_WDATA: S_AXI_RDATA_O <= 32'h00000000;
        default: begin
          S_AXI_RDATA_O <= 32'h00000000;
          S_AXI_RRESP_O <= 2'b10;
        end
      endcase
    end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_ARREADY_O <= 1'b1;
    end
  end
endmodule : zcmd_host

// [zcmd_if.sv]
// Purpose: byte command channel between host and codec
// Assumes: one clock, valid/ready handshake on each direction
// Notes: host sends command then data bytes; device returns read bytes
`timescale 1ns/1ps
interface zcmd_if;
  logic [7:0] h2d_data;
  logic h2d_valid;
  logic h2d_ready;
  logic [7:0] d2h_data;
  logic d2h_valid;
  logic d2h_ready;
  modport device (input h2d_data, input h2d_valid, output h2d_ready,
                  output d2h_data, output d2h_valid, input d2h_ready);
  modport host (output h2d_data, output h2d_valid, input h2d_ready,
                input d2h_data, input d2h_valid, output d2h_ready);
endinterface : zcmd_if

// [zcmd_pkg.sv]
// Purpose: shared constants for the command port between host and codec
// Assumes: byte-wide command port with valid/ready handshakes
// Notes: coefficient words pack sign in bit 3 and shift count below it
package zcmd_pkg;
  localparam logic [7:0] CMD_FIR_WR = 8'h98;
  localparam logic [7:0] CMD_FIR_RD = 8'h99;
  localparam logic [7:0] CMD_IIR_WR = 8'h9A;
  localparam logic [7:0] CMD_IIR_RD = 8'h9B;
  localparam logic [7:0] CMD_DEB_WR = 8'hC8;
  localparam logic [7:0] CMD_DEB_RD = 8'hC9;
  localparam logic [7:0] CMD_XMT_RD = 8'hCD;
  localparam int FIR_BYTES = 10;
  localparam int IIR_BYTES = 5;
  localparam int XMT_BYTES = 2;
  localparam logic [15:0] COEF_PAIR_RESET = 16'h0190;
  localparam logic [79:0] FIR_RESET = {5{COEF_PAIR_RESET}};
  localparam logic [39:0] IIR_RESET = {COEF_PAIR_RESET, COEF_PAIR_RESET,
                                       COEF_PAIR_RESET[7:0]};
  // config byte: bit7 mux enable, bit6 polarity, bits5:2 debounce, bit0 chop
  localparam int CFG_MUX_EN = 7;
  localparam int CFG_POL = 6;
  localparam int CFG_DEB_LSB = 2;
  localparam int CFG_CHOP = 0;
  localparam logic [7:0] CFG_RESET = 8'h20;
  localparam int CLK_HZ = 50_000_000;
  localparam int MS_CYCLES = CLK_HZ / 1000;
  localparam int FILT_HZ = 32_000;
  localparam int FILT_CYCLES = CLK_HZ / FILT_HZ;
  localparam int CHOP_HZ = 256_000;
  localparam int CHOP_HALF = CLK_HZ / (2 * CHOP_HZ);
  // host register map, word aligned
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_WDATA = 4'h4;
  localparam logic [3:0] REG_RDATA = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hC;
endpackage : zcmd_pkg

// [zcmd_props.sv]
// Purpose: checks on the byte channel between host and codec ends
// Assumes: one clock, reset active low, commands per the shared package
// Notes: helper counters track framing; unknown commands are skipped
`timescale 1ns/1ps
module zcmd_props (
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  input wire logic [7:0] h2d_data,
  input wire logic h2d_valid,
  input wire logic h2d_ready,
  input wire logic [7:0] d2h_data,
  input wire logic d2h_valid,
  input wire logic d2h_ready
);
  import zcmd_pkg::*;
  logic [3:0] wr_left;
  logic [3:0] rd_left;
  logic [7:0] rd_cmd;
  logic h_go;
  logic d_go;
  logic cmd_go;
  assign h_go = h2d_valid && h2d_ready;
  assign d_go = d2h_valid && d2h_ready;
  assign cmd_go = h_go && wr_left == 4'h0 && rd_left == 4'h0;
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      wr_left <= 4'h0;
    end else if (cmd_go) begin
      case (h2d_data)
        CMD_FIR_WR: wr_left <= 4'hA;
        CMD_IIR_WR: wr_left <= 4'h5;
        CMD_DEB_WR: wr_left <= 4'h1;
        default: wr_left <= 4'h0;
      endcase
    end else if (h_go && wr_left != 4'h0) begin
      wr_left <= wr_left - 4'h1;
    end
  end
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rd_left <= 4'h0;
      rd_cmd <= 8'h00;
    end else if (cmd_go) begin
      rd_cmd <= h2d_data;
      case (h2d_data)
        CMD_FIR_RD: rd_left <= 4'hA;
        CMD_IIR_RD: rd_left <= 4'h5;
        CMD_DEB_RD: rd_left <= 4'h1;
        CMD_XMT_RD: rd_left <= 4'h2;
        default: rd_left <= 4'h0;
      endcase
    end else if (d_go) begin
      rd_left <= rd_left - 4'h1;
    end
  end
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RESET_N_I);
  a_fir_rd_first: assert property (
    cmd_go && h2d_data == CMD_FIR_RD |-> ##2 d2h_valid)
    else $error("fir read gave no first byte in time");
  a_iir_rd_first: assert property (
    cmd_go && h2d_data == CMD_IIR_RD |-> ##2 d2h_valid)
    else $error("iir read gave no first byte in time");
  a_deb_rd_first: assert property (
    cmd_go && h2d_data == CMD_DEB_RD |-> ##2 d2h_valid)
    else $error("config read gave no byte in time");
  a_xmt_reserved_bits_zero: assert property (
    d2h_valid && rd_cmd == CMD_XMT_RD && rd_left == 4'h1 |-> d2h_data == 8'h00)
    else $error("second sample byte not zero");
  a_no_extra_bytes: assert property (
    d2h_valid |-> rd_left != 4'h0)
    else $error("read byte beyond command length");
  a_next_byte_gap: assert property (
    d_go && rd_left > 4'h1 |=> !d2h_valid ##1 d2h_valid)
    else $error("next read byte out of step");
  a_valid_holds: assert property (
    d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_data))
    else $error("read byte dropped or changed while stalled");
  a_ready_low_read: assert property (
    rd_left != 4'h0 |-> !h2d_ready)
    else $error("device took a byte while answering");
  a_write_silent: assert property (
    wr_left != 4'h0 |-> !d2h_valid)
    else $error("device answered during a write");
  c_fir_write: cover property (cmd_go && h2d_data == CMD_FIR_WR);
  c_xmt_read: cover property (cmd_go && h2d_data == CMD_XMT_RD);
  c_iir_byte: cover property (d_go && rd_cmd == CMD_IIR_RD);
endmodule : zcmd_props
